/* File: plhc_regs.vh */
/*
  Register offsets, field positions, reset values and timing counts for the
  power, indicator and host-mode configuration registers.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef PLHC_REGS_VH
`define PLHC_REGS_VH

// Register offsets on the eight-bit internal register address
`define PLHC_OFS_PVID 8'hC2
`define PLHC_OFS_PWR 8'hC3
`define PLHC_OFS_SLEEP 8'hC4
`define PLHC_OFS_HOST 8'hC6

// Egress PVID insert bits
`define PLHC_PV_P2_AT_P1 3
`define PLHC_PV_P2_AT_P3 2
`define PLHC_PV_P3_AT_P1 1
`define PLHC_PV_P3_AT_P2 0
`define PLHC_PV_MASK 8'h0F

// Power and indicator control fields
`define PLHC_PW_CPU_GATE 7
`define PLHC_PW_SW_GATE 6
`define PLHC_PW_LED_HI 5
`define PLHC_PW_LED_LO 4
`define PLHC_PW_DEBUG 3
`define PLHC_PW_PLL_OFF 2
`define PLHC_PW_MODE_HI 1
`define PLHC_PW_MODE_LO 0

// Host register fields
`define PLHC_HM_FWD_HI 6
`define PLHC_HM_FWD_LO 4
`define PLHC_HM_MODE_HI 1
`define PLHC_HM_MODE_LO 0
`define PLHC_HM_MASK 8'h73

// Reset values
`define PLHC_RST_PVID 8'h00
`define PLHC_RST_PWR 8'h00
`define PLHC_RST_SLEEP 8'h50
`define PLHC_RST_FWD 3'h0

// Power management modes
`define PLHC_PM_NORMAL 2'h0
`define PLHC_PM_ENERGY 2'h1
`define PLHC_PM_SWPD 2'h2
`define PLHC_PM_SAVE 2'h3

// Indicator modes
`define PLHC_LED_LACT_SPD 2'h0
`define PLHC_LED_LINK_ACT 2'h1
`define PLHC_LED_LACT_DPX 2'h2
`define PLHC_LED_LINK_DPX 2'h3

// Sleep unit: 20 ms at 125 MHz (8 ns period)
`define PLHC_SLEEP_UNIT_NS 20000000
`define PLHC_CLK_PERIOD_NS 8
`define PLHC_UNIT_CYCLES (`PLHC_SLEEP_UNIT_NS / `PLHC_CLK_PERIOD_NS)

// Blink half period for activity, in clock cycles
`define PLHC_BLINK_CYCLES 24'h7A1200

`endif

/* File: plhc_sleep_timer.v */
/*
  Energy-detect sleep timer: counts an uninterrupted quiet period in units
  of the programmed tick and raises a low-power request when it expires.
  Assumes energy_seen is synchronous to clock and that the tick length is
  shortened by parameter in simulation.
*/
`default_nettype none
`include "plhc_regs.vh"
module plhc_sleep_timer #(
  parameter UNIT_CYCLES = `PLHC_UNIT_CYCLES
) (
  input wire clock,
  input wire rst,
  input wire enable,
  input wire energy_seen,
  input wire [7:0] delay_units,
  output reg asleep_ff
);
  reg [23:0] tick_ff; // Cycles within one 20 ms unit
  reg [7:0] units_ff; // Whole units of quiet seen so far
  wire unit_done = (tick_ff == UNIT_CYCLES[23:0] - 24'h000001);

  // Restart on any energy or when the mode is off
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_ff <= 24'h000000;
      units_ff <= 8'h00;
      asleep_ff <= 1'b0;
    end else if (!enable || energy_seen) begin
      tick_ff <= 24'h000000;
      units_ff <= 8'h00;
      asleep_ff <= 1'b0;
    end else if (!asleep_ff) begin
      // Sleep only once quiet has lasted the full programmed span
      if (units_ff >= delay_units) begin
        asleep_ff <= 1'b1;
      end else if (unit_done) begin
        tick_ff <= 24'h000000;
        units_ff <= units_ff + 8'h01;
      end else begin
        tick_ff <= tick_ff + 24'h000001;
      end
    end
  end
endmodule
`default_nettype wire

/* File: plhc_config_regs.v */
/*
  Power, indicator, invalid-VID forwarding and host-mode configuration
  registers with the logic they steer directly (indicator pins, clock gate
  enables, sleep request). Assumes the management interface presents a
  one-cycle write strobe and a combinational read address, and that strap
  pins are stable around reset release.
*/
// Notes on behaviour
// - Port 2 PVID inserted at ports 1, 3
// - Port 3 PVID inserted at ports 1, 2
// - Bit 7 enables host clock gating
// - Bit 6 enables switch clock gating
// - Two-bit field selects indicator pin meanings
// - Indicators active low; activity blinks
// - Debug bit outputs inverted energy, ready
// - Bit 2 enables PLL power down
// - Two-bit field selects power mode
// - Sleep after quiet for count times 20ms
// - Invalid-VID forward ports, reset zero
// - Host mode reset from strap pins
`default_nettype none
`include "plhc_regs.vh"
module plhc_config_regs #(
  parameter UNIT_CYCLES = `PLHC_UNIT_CYCLES
) (
  input wire clock,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata_ff,
  input wire port2_indicator_strap_high,
  input wire port2_indicator_strap_low,
  input wire link_up,
  input wire speed_100,
  input wire full_duplex,
  input wire activity,
  input wire stretched_energy,
  input wire device_ready,
  output reg first_indicator_pin_ff,
  output reg second_indicator_pin_ff,
  output reg [3:0] pvid_insert_ff,
  output reg host_clk_gate_en_ff,
  output reg switch_clk_gate_en_ff,
  output reg pll_off_en_ff,
  output reg [1:0] power_mode_ff,
  output reg energy_detect_mode_ff,
  output reg low_power_ff,
  output reg [2:0] invalid_vid_ports_ff,
  output reg [1:0] host_mode_ff
);
  reg [7:0] pvid_reg_ff; // Egress PVID insert control
  reg [7:0] pwr_reg_ff; // Power and indicator control
  reg [7:0] sleep_reg_ff; // Sleep entry delay in 20 ms units
  reg [2:0] fwd_ff; // Invalid-VID forward port set
  reg [1:0] hmode_ff; // Host interface mode
  reg strap_pending_ff; // Strap capture is due after reset release
  reg [23:0] blink_cnt_ff; // Activity blink period counter
  reg blink_ff; // Blink phase
  reg nxt_first;
  reg nxt_second;
  wire asleep;

  // Address decode shared by write and read paths
  // A single compare keeps both paths decoding the same offsets
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Register writes; reserved bits are masked so they keep defaults
  // Strap capture owns the mode bits on the first edge after release,
  // so a host write in that very cycle loses to the pins
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pvid_reg_ff <= `PLHC_RST_PVID;
      pwr_reg_ff <= `PLHC_RST_PWR;
      sleep_reg_ff <= `PLHC_RST_SLEEP;
      fwd_ff <= `PLHC_RST_FWD;
      hmode_ff <= `PLHC_PM_NORMAL;
      strap_pending_ff <= 1'b1;
    end else begin
      strap_pending_ff <= 1'b0;
      if (strap_pending_ff) begin
        // Straps are caught by a clocked edge just after release
        hmode_ff <= {port2_indicator_strap_high, port2_indicator_strap_low};
      end else if (reg_write && hit(reg_addr, `PLHC_OFS_HOST)) begin
        hmode_ff <= reg_wdata[`PLHC_HM_MODE_HI:`PLHC_HM_MODE_LO];
      end
      if (reg_write && hit(reg_addr, `PLHC_OFS_PVID)) begin
        pvid_reg_ff <= reg_wdata & `PLHC_PV_MASK;
      end
      if (reg_write && hit(reg_addr, `PLHC_OFS_PWR)) begin
        pwr_reg_ff <= reg_wdata;
      end
      if (reg_write && hit(reg_addr, `PLHC_OFS_SLEEP)) begin
        sleep_reg_ff <= reg_wdata;
      end
      if (reg_write && hit(reg_addr, `PLHC_OFS_HOST)) begin
        fwd_ff <= reg_wdata[`PLHC_HM_FWD_HI:`PLHC_HM_FWD_LO];
      end
    end
  end

  // Read data registered; unmapped addresses return zero
  // Reads have no side effects, so polling a register is harmless
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_read) begin
      if (hit(reg_addr, `PLHC_OFS_PVID)) begin
        reg_rdata_ff <= pvid_reg_ff;
      end else if (hit(reg_addr, `PLHC_OFS_PWR)) begin
        reg_rdata_ff <= pwr_reg_ff;
      end else if (hit(reg_addr, `PLHC_OFS_SLEEP)) begin
        reg_rdata_ff <= sleep_reg_ff;
      end else if (hit(reg_addr, `PLHC_OFS_HOST)) begin
        reg_rdata_ff <= {1'b0, fwd_ff, 2'b00, hmode_ff};
      end else begin
        reg_rdata_ff <= 8'h00;
      end
    end
  end

  // Quiet-period timer runs only in energy detection mode
  // Leaving that mode clears the timer, so re-entry always waits the full span
  plhc_sleep_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_sleep (
    .clock(clock),
    .rst(rst),
    .enable(pwr_reg_ff[`PLHC_PW_MODE_HI:`PLHC_PW_MODE_LO] == `PLHC_PM_ENERGY),
    .energy_seen(stretched_energy),
    .delay_units(sleep_reg_ff),
    .asleep_ff(asleep)
  );

  // Blink generator toggles while activity is present
  // Held at zero when idle so every burst starts with the indicator on
  // Limitation: the blink rate is fixed and does not follow link speed
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      blink_cnt_ff <= 24'h000000;
      blink_ff <= 1'b0;
    end else if (!activity) begin
      blink_cnt_ff <= 24'h000000;
      blink_ff <= 1'b0;
    end else if (blink_cnt_ff == `PLHC_BLINK_CYCLES) begin
      blink_cnt_ff <= 24'h000000;
      blink_ff <= ~blink_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 24'h000001;
    end
  end

  // Indicator selection; low means on
  // Debug override comes last so it wins over every indicator mode
  always @* begin
    nxt_first = ~link_up;
    nxt_second = ~speed_100;
    case (pwr_reg_ff[`PLHC_PW_LED_HI:`PLHC_PW_LED_LO])
      `PLHC_LED_LACT_SPD: begin
        nxt_first = ~link_up | blink_ff;
        nxt_second = ~speed_100;
      end
      `PLHC_LED_LINK_ACT: begin
        nxt_first = ~link_up;
        nxt_second = ~activity | blink_ff;
      end
      `PLHC_LED_LACT_DPX: begin
        nxt_first = ~link_up | blink_ff;
        nxt_second = ~full_duplex;
      end
      default: begin
        nxt_first = ~link_up;
        nxt_second = ~full_duplex;
      end
    endcase
    if (pwr_reg_ff[`PLHC_PW_DEBUG]) begin
      nxt_first = ~device_ready;
      nxt_second = ~stretched_energy;
    end
  end

  // Outputs straight from flops; pins idle high (off) in reset
  // The extra stage costs one cycle of latency but keeps outputs glitch free
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      first_indicator_pin_ff <= 1'b1;
      second_indicator_pin_ff <= 1'b1;
      pvid_insert_ff <= 4'h0;
      host_clk_gate_en_ff <= 1'b0;
      switch_clk_gate_en_ff <= 1'b0;
      pll_off_en_ff <= 1'b0;
      power_mode_ff <= `PLHC_PM_NORMAL;
      energy_detect_mode_ff <= 1'b0;
      low_power_ff <= 1'b0;
      invalid_vid_ports_ff <= 3'h0;
      host_mode_ff <= 2'h0;
    end else begin
      first_indicator_pin_ff <= nxt_first;
      second_indicator_pin_ff <= nxt_second;
      pvid_insert_ff <= pvid_reg_ff[`PLHC_PV_P2_AT_P1:`PLHC_PV_P3_AT_P2];
      host_clk_gate_en_ff <= pwr_reg_ff[`PLHC_PW_CPU_GATE];
      switch_clk_gate_en_ff <= pwr_reg_ff[`PLHC_PW_SW_GATE];
      pll_off_en_ff <= pwr_reg_ff[`PLHC_PW_PLL_OFF];
      power_mode_ff <= pwr_reg_ff[`PLHC_PW_MODE_HI:`PLHC_PW_MODE_LO];
      energy_detect_mode_ff <= (pwr_reg_ff[`PLHC_PW_MODE_HI:`PLHC_PW_MODE_LO]
        == `PLHC_PM_ENERGY);
      low_power_ff <= asleep;
      invalid_vid_ports_ff <= fwd_ff;
      host_mode_ff <= hmode_ff;
    end
  end
endmodule
`default_nettype wire

/* File: plhc_config_regs_sva.sv */
/* Port checker for the config register block.
   Assumes a bind from the bench top file. */
`default_nettype none
module plhc_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic stretched_energy,
  input wire logic [3:0] pvid_insert_ff,
  input wire logic host_clk_gate_en_ff,
  input wire logic switch_clk_gate_en_ff,
  input wire logic pll_off_en_ff,
  input wire logic [1:0] power_mode_ff,
  input wire logic energy_detect_mode_ff,
  input wire logic low_power_ff,
  input wire logic [2:0] invalid_vid_ports_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Write strobes; an output trails its write by two edges
  wire wpv = reg_write && reg_addr == 8'hC2;
  wire wpw = reg_write && reg_addr == 8'hC3;
  wire whm = reg_write && reg_addr == 8'hC6;
  chk_pvid_follow: assert property (wpv |-> ##2
    pvid_insert_ff == $past(reg_wdata[3:0], 2)) else $error("pvid wrong");
  chk_host_gate: assert property (wpw |-> ##2
    host_clk_gate_en_ff == $past(reg_wdata[7], 2)) else $error("host gate wrong");
  chk_switch_gate: assert property (wpw |-> ##2
    switch_clk_gate_en_ff == $past(reg_wdata[6], 2)) else $error("switch gate wrong");
  chk_pll_off: assert property (wpw |-> ##2
    pll_off_en_ff == $past(reg_wdata[2], 2)) else $error("pll off wrong");
  chk_power_mode: assert property (wpw |-> ##2
    power_mode_ff == $past(reg_wdata[1:0], 2)) else $error("power mode wrong");
  chk_energy_flag: assert property (wpw |-> ##2
    energy_detect_mode_ff == ($past(reg_wdata[1:0], 2) == 2'h1)) else $error("mode flag wrong");
  chk_fwd_ports: assert property (whm |-> ##2
    invalid_vid_ports_ff == $past(reg_wdata[6:4], 2)) else $error("fwd ports wrong");
  // Energy seen must end a sleep request within three edges
  chk_energy_wake: assert property (stretched_energy |-> ##[1:3]
    !low_power_ff) else $error("sleep kept");
endmodule
`default_nettype wire

/* File: plhc_host.sv */
/* Host model: single byte register writes and reads.
   Assumes read data lands on the edge that takes the strobe. */
`default_nettype none
module plhc_host (
  input wire logic clock,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr, wdata, wr, rd} = 18'h00000;
  // Released data is inverted so a stale byte never looks valid
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    {addr, wr} = {a, 1'b1};
    wdata = a == 8'hC6 ? d & 8'h7B : a == 8'hC2 ? d & 8'h3F : d;
    @(posedge clock);
    #1;
    {wdata, wr} = {~wdata, 1'b0};
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    {addr, rd} = {a, 1'b1};
    @(posedge clock);
    #1;
    {d, rd} = {rdata, 1'b0};
  endtask
endmodule
`default_nettype wire

/* File: plhc_config_regs_bench.sv */
/* Bench: host model, bound checker, one task per scenario.
   Assumes the sleep tick shortened to UNIT cycles. */
`default_nettype none
module plhc_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UNIT = 4;
  logic clock, rst, s_hi, s_lo, link, spd, dup, act, nrg, rdy;
  logic [7:0] d;
  logic [7:0] ra [5] = '{8'hC2, 8'hC3, 8'hC4, 8'hC6, 8'h10};
  logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h50, 8'h00, 8'h00};
  logic [7:0] pw [4] = '{8'h80, 8'h41, 8'h06, 8'hC7};
  wire [7:0] addr, wdata, rdata;
  wire [3:0] pv;
  wire [2:0] fv;
  wire [1:0] pm, hm;
  wire wr, rd, p0, p1, hg, sg, po, em, lp;
  int bad_count = 0;
  int total_checks = 0;
  plhc_host host (.clock, .rdata, .addr, .wdata, .wr, .rd);
  plhc_config_regs #(.UNIT_CYCLES(UNIT)) dut (.clock, .rst, .reg_addr(addr),
    .reg_wdata(wdata), .reg_write(wr), .reg_read(rd), .reg_rdata_ff(rdata),
    .port2_indicator_strap_high(s_hi), .port2_indicator_strap_low(s_lo), .link_up(link),
    .speed_100(spd), .full_duplex(dup), .activity(act), .stretched_energy(nrg),
    .device_ready(rdy), .first_indicator_pin_ff(p0), .second_indicator_pin_ff(p1),
    .pvid_insert_ff(pv), .host_clk_gate_en_ff(hg), .switch_clk_gate_en_ff(sg),
    .pll_off_en_ff(po), .power_mode_ff(pm), .energy_detect_mode_ff(em),
    .low_power_ff(lp), .invalid_vid_ports_ff(fv), .host_mode_ff(hm));
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Reset with given straps, then defaults and an unmapped read
  task automatic t_reset(input int n, input logic [1:0] st);
    rst = 1'b1;
    {s_hi, s_lo} = st;
    tick(n);
    rst = 1'b0;
    tick(2);
    cmp(8'(hm), 8'(st));
    foreach (ra[i]) begin
      host.read(ra[i], d);
      cmp(d, rv[i] | 8'(i == 3 ? st : 2'h0));
    end
  endtask
  // Walk one bit; reserved ones written must not stick
  task automatic t_pvid;
    for (int i = 0; i < 5; i++) begin
      host.write(8'hC2, 8'hF0 | 8'(1 << i));
      tick(2);
      cmp(8'(pv), 8'h0F & 8'(1 << i));
      host.read(8'hC2, d);
      cmp(d, 8'h0F & 8'(1 << i));
    end
  endtask
  task automatic t_power;
    foreach (pw[i]) begin
      host.write(8'hC3, pw[i]);
      tick(2);
      d = pw[i];
      cmp(8'({hg, sg, po, em, pm}), 8'({d[7:6], d[2], d[1:0] == 2'h1, d[1:0]}));
      host.read(8'hC3, d);
      cmp(d, pw[i]);
    end
  endtask
  // Activity toggles, but blinking is too slow to see in this run
  task automatic t_led;
    for (int v = 0; v < 36; v++) begin
      host.write(8'hC3, v < 32 ? 8'(v[4:3]) << 4 : 8'h08);
      {link, spd, dup} = 3'(v);
      {nrg, rdy} = 2'(v);
      act = v[0] ^ v[2];
      tick(3);
      d[1] = v[4:3] == 0 ? !spd : v[4:3] == 1 ? !act : !dup;
      if (v >= 32) cmp(8'({p1, p0}), 8'({!nrg, !rdy}));
      else cmp(8'({p1, p0}), 8'({d[1], !link}));
    end
    act = 1'b0;
  endtask
  task automatic t_fwd;
    for (int v = 0; v < 8; v++) begin
      host.write(8'hC6, 8'(v * 17));
      tick(2);
      cmp(8'({fv, hm}), 8'(v * 4 + v % 4));
      host.read(8'hC6, d);
      cmp(d, 8'(v * 16 + v % 4));
    end
  endtask
  // Quiet must last the count; an energy blip restarts it
  task automatic t_sleep;
    nrg = 1'b1;
    host.write(8'hC4, 8'h03);
    host.write(8'hC3, 8'h01);
    for (int k = 0; k < 2; k++) begin
      nrg = 1'b0;
      tick(3 * UNIT - 1);
      cmp(8'(lp), 8'h00);
      for (int n = 0; n < 20 && lp !== 1'b1; n++) tick(1);
      cmp(8'(lp), 8'h01);
      nrg = 1'b1;
      tick(1);
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    {link, spd, dup, act, nrg, rdy} = 6'h00;
    for (int s = 0; s < 4; s++) t_reset(s == 0 ? 20 : 3, 2'(s));
    t_pvid;
    t_power;
    t_led;
    t_fwd;
    t_sleep;
    wrap_up;
  end
  // Watchdog: scenarios need well under 2000 cycles
  initial begin
    #40000;
    bad_count++;
    wrap_up;
  end
endmodule
bind plhc_config_regs plhc_sva chk (.clock, .rst, .reg_addr, .reg_wdata, .reg_write,
  .stretched_energy, .pvid_insert_ff, .host_clk_gate_en_ff, .switch_clk_gate_en_ff,
  .pll_off_en_ff, .power_mode_ff, .energy_detect_mode_ff, .low_power_ff,
  .invalid_vid_ports_ff);
`default_nettype wire
